// *** hdl/ewl_pkg.sv ***
// Purpose: constants shared by the event input wake logic
// Assumes: 125 MHz resume-well clock, 32-bit classic Wishbone
// Notes: sleep state codes follow the sleep-state machine encoding
`default_nettype none
package ewl_pkg;
    // ********************************************
    // clock and timing
    // ********************************************
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned DEBOUNCE_MS = 16;
    localparam int unsigned HOLD_S = 4;
    localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
    localparam int unsigned HOLD_CYC = CLK_HZ * HOLD_S;
    // ********************************************
    // sleep state encoding
    // ********************************************
    localparam logic [2:0] ST_S0 = 3'h0;
    localparam logic [2:0] ST_S1 = 3'h1;
    localparam logic [2:0] ST_S4 = 3'h4;
    localparam logic [2:0] ST_S5 = 3'h5;
    // ********************************************
    // register byte offsets
    // ********************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LEVEL = 8'h04;
    localparam logic [7:0] OFS_EVT_STS = 8'h08;
    localparam logic [7:0] OFS_EVT_CLR = 8'h0c;
    localparam logic [7:0] OFS_EVT_EN = 8'h10;
    // ********************************************
    // field positions
    // ********************************************
    localparam int CTRL_SCI_SELECT = 0;
    localparam int CTRL_RING_WAKE_ENABLE = 1;
    localparam int CTRL_PME_WAKE_ENABLE = 2;
    localparam int LVL_BUTTON = 0;
    localparam int LVL_RING = 1;
    localparam int LVL_PME = 2;
    localparam int LVL_STATE_LSB = 4;
    localparam int EVT_BUTTON = 0;
    localparam int EVT_PME = 1;
    localparam int EVT_WAKE = 2;
    localparam int EVT_OVERRIDE = 3;
    localparam int EVT_W = 4;
    // ********************************************
    // reset values
    // ********************************************
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [EVT_W-1:0] EVT_RST = 4'h0;
endpackage : ewl_pkg
`default_nettype wire

// *** hdl/ewl_dbn_if.sv ***
// Purpose: carries the raw button pin and the filtered result
// Assumes: one clock domain
// Notes: press is a one-cycle pulse on a new pressed level
`default_nettype none
interface ewl_dbn_if;
    logic raw_n;
    logic pressed;
    logic press;
    modport filt (input raw_n, output pressed, output press);
    modport user (output raw_n, input pressed, input press);
endinterface : ewl_dbn_if
`default_nettype wire

// *** hdl/ewl_debounce.sv ***
// Purpose: power button synchroniser and stable-level filter
// Assumes: raw_n is an asynchronous pin, low while pressed
// Notes: reset forces the released level so no press is held over
`default_nettype none
module ewl_debounce
    import ewl_pkg::*;
#(
    parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    ewl_dbn_if.filt dbn
);
    logic [1:0] sync_reg;
    logic [31:0] cnt_reg;
    logic level_reg;
    logic press_reg;
    // ********************************************
    // two-stage synchroniser
    // ********************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync_reg <= 2'h3;
        end else begin
            sync_reg <= {sync_reg[0], dbn.raw_n};
        end
    end
    // ********************************************
    // accept a level only after it held for the full interval
    // ********************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= 32'h0;
            level_reg <= 1'b0;
            press_reg <= 1'b0;
        end else begin
            press_reg <= 1'b0;
            if (sync_reg[1] == level_reg) begin
                // sample disagrees with the accepted level: time it
                if (cnt_reg >= STABLE_CYC - 1) begin
                    cnt_reg <= 32'h0;
                    level_reg <= ~level_reg;
                    press_reg <= ~level_reg;
                end else begin
                    cnt_reg <= cnt_reg + 32'h1;
                end
            end else begin
                cnt_reg <= 32'h0;
            end
        end
    end
    assign dbn.pressed = level_reg;
    assign dbn.press = press_reg;
endmodule : ewl_debounce
`default_nettype wire

// *** hdl/ewl_event_wake.sv ***
// Purpose: power button, ring and PCI event inputs to irq, wake and off
// Assumes: I_SYS_RST is the resume-well reset; sleep state from same clock
// Notes: registers on classic Wishbone, one-cycle registered ack
`default_nettype none
module ewl_event_wake
    import ewl_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int unsigned HOLD_CYCLES = HOLD_CYC
) (
    input wire logic I_REF_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_POWER_BUTTON_N,
    input wire logic I_RING_INDICATE_N,
    input wire logic I_PCI_PME_N,
    input wire logic [2:0] I_SLEEP_STATE,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    output logic O_SYS_MGMT_IRQ_N,
    output logic O_SCI,
    output logic O_WAKE,
    output logic O_FORCE_SOFT_OFF,
    output logic O_IRQ
);
    // ********************************************
    // declarations
    // ********************************************
    ewl_dbn_if dbn ();
    logic [1:0] ring_sync_reg;
    logic [1:0] pme_sync_reg;
    logic pme_prev_reg;
    logic ring_cond_prev_reg;
    logic [2:0] ctrl_reg;
    logic [EVT_W-1:0] evt_sts_reg;
    logic [EVT_W-1:0] evt_en_reg;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    logic [31:0] hold_cnt_reg;
    logic hold_fired_reg;
    logic [31:0] rd_data;
    logic wb_req;
    logic wr_ok;
    logic in_s0;
    logic sleeping;
    logic ring_active;
    logic ring_cond;
    logic pme_fall;
    logic btn_press;
    logic btn_wake;
    logic ring_wake;
    logic pme_wake;
    logic override_hit;
    logic sci_select;
    logic ring_wake_enable;
    logic pme_wake_enable;
    logic smi_sci_src;

    // ********************************************
    // power button filter
    // ********************************************
    assign dbn.raw_n = I_POWER_BUTTON_N;

    ewl_debounce #(
        .STABLE_CYC(DEBOUNCE_CYCLES)
    ) u_debounce (
        .i_clk(I_REF_CLK),
        .i_rst(I_SYS_RST),
        .dbn(dbn.filt)
    );

    // ********************************************
    // ring and PCI event synchronisers
    // ********************************************
    // no filtering on the ring line: a glitch that survives the
    // synchroniser is taken as a ring
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            ring_sync_reg <= 2'h3;
        end else begin
            ring_sync_reg <= {ring_sync_reg[0], I_RING_INDICATE_N};
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            pme_sync_reg <= 2'h3;
        end else begin
            pme_sync_reg <= {pme_sync_reg[0], I_PCI_PME_N};
        end
    end

    // starts at the idle high level so reset gives no false fall
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            pme_prev_reg <= 1'b1;
        end else begin
            pme_prev_reg <= pme_sync_reg[1];
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            ring_cond_prev_reg <= 1'b0;
        end else begin
            ring_cond_prev_reg <= ring_cond;
        end
    end

    // ********************************************
    // event decode
    // ********************************************
    assign sci_select = ctrl_reg[CTRL_SCI_SELECT];
    assign ring_wake_enable = ctrl_reg[CTRL_RING_WAKE_ENABLE];
    assign pme_wake_enable = ctrl_reg[CTRL_PME_WAKE_ENABLE];
    assign in_s0 = (I_SLEEP_STATE == ST_S0);
    assign sleeping = (I_SLEEP_STATE >= ST_S1) && (I_SLEEP_STATE <= ST_S5);
    assign ring_active = ~ring_sync_reg[1];
    // only the high-to-low edge counts; the rising edge is dropped
    assign pme_fall = pme_prev_reg & ~pme_sync_reg[1];
    // reset holds the filter released, so G3 presses never register
    assign btn_press = dbn.press;
    assign btn_wake = btn_press & sleeping;
    assign ring_cond = ring_active & sleeping & ring_wake_enable;
    assign ring_wake = ring_cond & ~ring_cond_prev_reg;
    assign pme_wake = pme_fall & sleeping & pme_wake_enable;

    // ********************************************
    // four second hold timer
    // ********************************************
    // runs only while pressed in S0; a press held through a wake
    // restarts from zero once S0 is reached
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            hold_cnt_reg <= 32'h0;
        end else if (dbn.pressed && in_s0) begin
            if (hold_cnt_reg < HOLD_CYCLES - 1) begin
                hold_cnt_reg <= hold_cnt_reg + 32'h1;
            end
        end else begin
            hold_cnt_reg <= 32'h0;
        end
    end

    // one forced off per hold: only a release or leaving S0 rearms it
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            hold_fired_reg <= 1'b0;
        end else if (!(dbn.pressed && in_s0)) begin
            hold_fired_reg <= 1'b0;
        end else if (hold_cnt_reg >= HOLD_CYCLES - 1) begin
            hold_fired_reg <= 1'b1;
        end
    end

    assign override_hit = dbn.pressed && in_s0 && !hold_fired_reg
        && (hold_cnt_reg == HOLD_CYCLES - 1);

    // ********************************************
    // wake and forced off outputs
    // ********************************************
    // no handshake input exists: the request leaves the block directly
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_WAKE <= 1'b0;
        end else begin
            O_WAKE <= btn_wake | ring_wake | pme_wake;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_FORCE_SOFT_OFF <= 1'b0;
        end else begin
            O_FORCE_SOFT_OFF <= override_hit;
        end
    end

    // ********************************************
    // wishbone slave
    // ********************************************
    assign wb_req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
    assign wr_ok = wb_req & I_WB_WE & I_WB_SEL[0];

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_WB_ACK <= 1'b0;
        end else begin
            O_WB_ACK <= wb_req;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            ctrl_reg <= CTRL_RST;
        end else if (wr_ok && I_WB_ADR == OFS_CTRL) begin
            ctrl_reg <= I_WB_DAT[2:0];
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            evt_en_reg <= EVT_RST;
        end else if (wr_ok && I_WB_ADR == OFS_EVT_EN) begin
            evt_en_reg <= I_WB_DAT[EVT_W-1:0];
        end
    end

    always_comb begin
        rd_data = 32'h0;
        case (I_WB_ADR)
            OFS_CTRL: begin
                rd_data[2:0] = ctrl_reg;
            end
            OFS_LEVEL: begin
                rd_data[LVL_BUTTON] = dbn.pressed;
                rd_data[LVL_RING] = ring_active;
                rd_data[LVL_PME] = ~pme_sync_reg[1];
                rd_data[LVL_STATE_LSB +: 3] = I_SLEEP_STATE;
            end
            OFS_EVT_STS: begin
                rd_data[EVT_W-1:0] = evt_sts_reg;
            end
            OFS_EVT_EN: begin
                rd_data[EVT_W-1:0] = evt_en_reg;
            end
            default: begin
                rd_data = 32'h0;
            end
        endcase
    end

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_WB_DAT <= 32'h0;
        end else if (wb_req && !I_WB_WE) begin
            O_WB_DAT <= rd_data;
        end else begin
            O_WB_DAT <= 32'h0;
        end
    end

    // ********************************************
    // sticky event status
    // ********************************************
    always_comb begin
        evt_set = EVT_RST;
        evt_set[EVT_BUTTON] = btn_press;
        evt_set[EVT_PME] = pme_fall;
        evt_set[EVT_WAKE] = btn_wake | ring_wake | pme_wake;
        evt_set[EVT_OVERRIDE] = override_hit;
    end

    assign evt_clr = (wr_ok && I_WB_ADR == OFS_EVT_CLR) ? I_WB_DAT[EVT_W-1:0] : EVT_RST;

    // a set in the clearing cycle wins, so no press is lost
    genvar gi;
    generate
        for (gi = 0; gi < EVT_W; gi++) begin : g_sts
            always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
                if (I_SYS_RST) begin
                    evt_sts_reg[gi] <= 1'b0;
                end else if (evt_set[gi]) begin
                    evt_sts_reg[gi] <= 1'b1;
                end else if (evt_clr[gi]) begin
                    evt_sts_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ********************************************
    // SMI, SCI and interrupt outputs
    // ********************************************
    // button and PCI events hold their request until software clears
    // the status; in sleep they still latch and raise the request at once
    assign smi_sci_src = evt_sts_reg[EVT_BUTTON] | evt_sts_reg[EVT_PME];

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_SYS_MGMT_IRQ_N <= 1'b1;
        end else begin
            O_SYS_MGMT_IRQ_N <= ~(smi_sci_src & ~sci_select);
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_SCI <= 1'b0;
        end else begin
            O_SCI <= smi_sci_src & sci_select;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_IRQ <= 1'b0;
        end else begin
            O_IRQ <= |(evt_sts_reg & evt_en_reg);
        end
    end
endmodule : ewl_event_wake
`default_nettype wire

// *** tb/ewl_pin_model.sv ***
// Purpose: button, modem ring and PCI event pins facing the block
// Assumes: bench commands change just after a rising clock edge
// Notes: every button change bounces for three cycles, shorter than the filter
`default_nettype none
module ewl_pin_model (
    input wire logic i_clk,
    input wire logic i_press,
    input wire logic i_ring,
    input wire logic i_pme,
    output logic o_button_n,
    output logic o_ring_n,
    output logic o_pme_n
);
    logic last_reg = 1'b0;
    logic [1:0] bnc_reg = 2'h0;
    always_ff @(posedge i_clk) begin
        last_reg <= i_press;
        if (i_press != last_reg) begin
            bnc_reg <= 2'h3;
        end else if (bnc_reg != 2'h0) begin
            bnc_reg <= bnc_reg - 2'h1;
        end
    end
    // contact bounce flips the level each cycle until it settles
    assign o_button_n = (bnc_reg != 2'h0) ? bnc_reg[0] : ~i_press;
    // the modem cleans its own ring line, so it arrives unfiltered
    assign o_ring_n = ~i_ring;
    assign o_pme_n = ~i_pme;
endmodule // ewl_pin_model
`default_nettype wire

// *** tb/ewl_event_wake_checker.sv ***
// Purpose: port-level assertions for the event input wake block
// Assumes: one clock, asynchronous active-high reset
// Notes: button low counter saturates so long holds stay legal
`default_nettype none
module ewl_event_wake_checker
    import ewl_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYCLES = 8,
    parameter int unsigned HOLD_CYCLES = 50
) (
    input wire logic I_REF_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_POWER_BUTTON_N,
    input wire logic I_RING_INDICATE_N,
    input wire logic I_PCI_PME_N,
    input wire logic [2:0] I_SLEEP_STATE,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic O_WB_ACK,
    input wire logic O_SYS_MGMT_IRQ_N,
    input wire logic O_SCI,
    input wire logic O_WAKE,
    input wire logic O_FORCE_SOFT_OFF,
    input wire logic O_IRQ
);
    logic [31:0] low_cnt_reg;
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            low_cnt_reg <= 32'h0;
        end else if (I_POWER_BUTTON_N) begin
            low_cnt_reg <= 32'h0;
        end else if (low_cnt_reg != 32'hffffffff) begin
            low_cnt_reg <= low_cnt_reg + 32'h1;
        end
    end
    default clocking @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    AST_ACK_ONE: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK ##1 !O_WB_ACK)
        else $error("ack not a single next-cycle pulse");
    AST_WAKE_PULSE: assert property (O_WAKE |=> !O_WAKE)
        else $error("wake pulse too long");
    AST_FORCE_PULSE: assert property (O_FORCE_SOFT_OFF |=> !O_FORCE_SOFT_OFF)
        else $error("forced off pulse too long");
    AST_FORCE_S0: assert property (O_FORCE_SOFT_OFF |-> $past(I_SLEEP_STATE) == ST_S0)
        else $error("forced off outside working state");
    AST_FORCE_HOLD: assert property (O_FORCE_SOFT_OFF |-> low_cnt_reg >= HOLD_CYCLES)
        else $error("forced off before full hold");
    AST_IRQ_EXCL: assert property (!(O_SCI && !O_SYS_MGMT_IRQ_N))
        else $error("both interrupt kinds active");
    // ring and event pins idle means the wake must come from the button
    AST_WAKE_FILT: assert property (O_WAKE && I_PCI_PME_N && I_RING_INDICATE_N
        |-> low_cnt_reg >= DEBOUNCE_CYCLES)
        else $error("button wake before filter span");
    AST_RST_CLEAN: assert property ($fell(I_SYS_RST)
        |-> O_SYS_MGMT_IRQ_N && !O_SCI && !O_IRQ && !O_WAKE)
        else $error("status outputs not clear after reset");
    cover property (O_WAKE);
    cover property (O_FORCE_SOFT_OFF);
    cover property (O_SCI);
endmodule // ewl_event_wake_checker
bind ewl_event_wake ewl_event_wake_checker #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)
) u_chk (
    .I_REF_CLK(I_REF_CLK), .I_SYS_RST(I_SYS_RST), .I_POWER_BUTTON_N(I_POWER_BUTTON_N),
    .I_RING_INDICATE_N(I_RING_INDICATE_N), .I_PCI_PME_N(I_PCI_PME_N),
    .I_SLEEP_STATE(I_SLEEP_STATE), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
    .O_WB_ACK(O_WB_ACK), .O_SYS_MGMT_IRQ_N(O_SYS_MGMT_IRQ_N), .O_SCI(O_SCI),
    .O_WAKE(O_WAKE), .O_FORCE_SOFT_OFF(O_FORCE_SOFT_OFF), .O_IRQ(O_IRQ)
);
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: self-checking bench for the event input wake block
// Assumes: short filter and hold spans set through parameters
// Notes: wake and forced-off pulses are counted, checks compare deltas
`default_nettype none
module tb
    import ewl_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned DB = 8;
    localparam int unsigned HD = 50;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic press = 1'b0;
    logic ring = 1'b0;
    logic pme = 1'b0;
    logic [2:0] state = 3'h0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic btn_n, ring_n, pme_n, ack, smi_n, sci, wake, off, irq;
    int err_count = 0;
    int cmp_count = 0;
    int wakes = 0;
    int offs = 0;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        wakes <= wakes + int'(wake === 1'b1);
        offs <= offs + int'(off === 1'b1);
    end
    ewl_pin_model pins (.i_clk(clk), .i_press(press), .i_ring(ring), .i_pme(pme),
        .o_button_n(btn_n), .o_ring_n(ring_n), .o_pme_n(pme_n));
    ewl_event_wake #(.DEBOUNCE_CYCLES(DB), .HOLD_CYCLES(HD)) dut (
        .I_REF_CLK(clk), .I_SYS_RST(rst), .I_POWER_BUTTON_N(btn_n),
        .I_RING_INDICATE_N(ring_n), .I_PCI_PME_N(pme_n), .I_SLEEP_STATE(state),
        .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
        .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_SYS_MGMT_IRQ_N(smi_n),
        .O_SCI(sci), .O_WAKE(wake), .O_FORCE_SOFT_OFF(off), .O_IRQ(irq));
    // ********************************************
    // bus and compare helpers
    // ********************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // holds the request until ack is sampled, then idles one cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        q = rdat;
        chk(32'(n < 16), 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic t_regs();
        rd(OFS_CTRL, 32'h0);
        rd(OFS_EVT_STS, 32'h0);
        rd(OFS_LEVEL, 32'h0);
        wr(OFS_CTRL, 32'h7);
        rd(OFS_CTRL, 32'h7);
        sel <= 4'he;
        wr(OFS_CTRL, 32'h0);
        sel <= 4'hf;
        rd(OFS_CTRL, 32'h7);
        wr(OFS_EVT_STS, 32'hf);
        rd(OFS_EVT_STS, 32'h0);
        rd(8'h40, 32'h0);
        wr(OFS_CTRL, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_g3();
        int w0;
        w0 = wakes;
        state <= 3'h3;
        rst <= 1'b1;
        press <= 1'b1;
        tick(DB * 3);
        press <= 1'b0;
        tick(6);
        rst <= 1'b0;
        tick(DB * 3);
        rd(OFS_EVT_STS, 32'h0);
        chk(wakes - w0, 0);
        state <= ST_S0;
        $display("test g3 done");
    endtask
    task automatic t_s0();
        int w0;
        w0 = wakes;
        press <= 1'b1;
        tick(5);
        press <= 1'b0;
        tick(20);
        rd(OFS_EVT_STS, 32'h0);
        press <= 1'b1;
        tick(DB + 12);
        rd(OFS_LEVEL, 32'h1);
        rd(OFS_EVT_STS, 32'h1);
        chk({31'h0, smi_n}, 32'h0);
        chk({31'h0, sci}, 32'h0);
        press <= 1'b0;
        tick(DB + 12);
        rd(OFS_LEVEL, 32'h0);
        rd(OFS_EVT_STS, 32'h1);
        wr(OFS_EVT_CLR, 32'h1);
        tick(2);
        chk({31'h0, smi_n}, 32'h1);
        wr(OFS_CTRL, 32'h1);
        press <= 1'b1;
        tick(DB + 12);
        chk({31'h0, sci}, 32'h1);
        chk({31'h0, smi_n}, 32'h1);
        press <= 1'b0;
        tick(DB + 12);
        chk(wakes - w0, 0);
        wr(OFS_EVT_CLR, 32'hf);
        wr(OFS_CTRL, 32'h0);
        $display("test s0 press done");
    endtask
    // long sleep stretch: a timer counting there would fire early
    task automatic t_hold();
        int w0;
        int f0;
        w0 = wakes;
        f0 = offs;
        state <= 3'h3;
        press <= 1'b1;
        tick(DB + 30);
        chk(wakes - w0, 1);
        state <= ST_S0;
        tick(HD - 10);
        chk(offs - f0, 0);
        tick(20);
        chk(offs - f0, 1);
        press <= 1'b0;
        tick(DB + 12);
        rd(OFS_EVT_STS, 32'hd);
        wr(OFS_EVT_CLR, 32'hf);
        $display("test hold done");
    endtask
    task automatic t_ring();
        int w0;
        w0 = wakes;
        wr(OFS_CTRL, 32'h2);
        ring <= 1'b1;
        tick(10);
        chk(wakes - w0, 0);
        ring <= 1'b0;
        wr(OFS_CTRL, 32'h0);
        state <= 3'h5;
        ring <= 1'b1;
        tick(10);
        chk(wakes - w0, 0);
        wr(OFS_CTRL, 32'h2);
        tick(10);
        chk(wakes - w0, 1);
        ring <= 1'b0;
        wr(OFS_CTRL, 32'h0);
        state <= ST_S0;
        $display("test ring done");
    endtask
    task automatic t_pme();
        int w0;
        w0 = wakes;
        state <= 3'h1;
        wr(OFS_CTRL, 32'h1);
        pme <= 1'b1;
        tick(10);
        chk(wakes - w0, 0);
        chk({31'h0, sci}, 32'h1);
        rd(OFS_LEVEL, 32'h14);
        pme <= 1'b0;
        tick(10);
        wr(OFS_EVT_CLR, 32'hf);
        wr(OFS_CTRL, 32'h4);
        wr(OFS_EVT_EN, 32'h2);
        pme <= 1'b1;
        tick(10);
        chk(wakes - w0, 1);
        chk({31'h0, smi_n}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_EVT_EN, 32'h0);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_EVT_EN, 32'h2);
        tick(2);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_EVT_CLR, 32'hf);
        pme <= 1'b0;
        tick(10);
        chk({31'h0, irq}, 32'h0);
        rd(OFS_EVT_STS, 32'h0);
        chk(wakes - w0, 1);
        wr(OFS_CTRL, 32'h0);
        state <= ST_S0;
        $display("test pme done");
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        t_regs();
        t_g3();
        t_s0();
        t_hold();
        t_ring();
        t_pme();
        finish_test();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        $display("[ERR] %0t watchdog got %h exp %h", $time, 32'h1, 32'h0);
        finish_test();
    end
endmodule // tb
`default_nettype wire
